//--- rtl/dsc_consts.vh
// Constants for the sample conditioning block
`ifndef DSC_CONSTS_VH
`define DSC_CONSTS_VH
// Output waveform modes
`define DSC_MODE_W 3
`define DSC_MODE_HOLD 3'h0
`define DSC_MODE_RTZ 3'h1
`define DSC_MODE_MIX 3'h2
`define DSC_MODE_DE_UNIQUE 3'h3
`define DSC_MODE_DE_LOWPASS 3'h4
`define DSC_MODE_DE_HIGHPASS 3'h5
// Datapath widths
`define DSC_SAMPLE_W 16
`define DSC_WIDE_W 18
`define DSC_OFS_W 13
// Offset saturation limits
`define DSC_OFS_LIM_DITH 13'h0080
`define DSC_OFS_LIM_NODITH 13'h0f80
// Code extremes
`define DSC_CODE_MAX 18'h07fff
`define DSC_CODE_MIN 18'h38000
// Dither
`define DSC_DITH_STEPS 8
`define DSC_DITH_IDX_W 3
`define DSC_DITH_STEP_SHIFT 4
// Segment partition
`define DSC_UPPER_SEGS 15
`define DSC_MIDDLE_SEGS 15
`define DSC_LOWER_BITS 8
`define DSC_SEG_IDX_W 4
// Pseudo-random generator
`define DSC_LFSR_W 16
`define DSC_LFSR_SEED 16'hace1
`define DSC_LFSR_TAPS 16'hb400
// Current and rate field widths
`define DSC_COARSE_W 4
`define DSC_FINE_W 6
`define DSC_RATE_W 4
`endif

//--- rtl/dsc_channel.v
// One converter channel: offset saturation, dither, shuffling and segment decode
`timescale 1ns/10ps
`include "dsc_consts.vh"
module dsc_channel #(
  parameter SEED = `DSC_LFSR_SEED
) (
  input wire clk_i,
  input wire reset_i,
  input wire sample_valid_i,
  input wire [`DSC_SAMPLE_W-1:0] sample_i,
  input wire [`DSC_OFS_W-1:0] offset_i,
  input wire dither_en_i,
  input wire shuffle_en_i,
  input wire shuffle_activity_i,
  input wire [`DSC_RATE_W-1:0] shuffle_rate_i,
  input wire [`DSC_RATE_W-1:0] dither_rate_i,
  output reg [`DSC_UPPER_SEGS-1:0] upper_seg_o,
  output reg [`DSC_MIDDLE_SEGS-1:0] middle_seg_o,
  output reg [`DSC_LOWER_BITS-1:0] lower_bits_o,
  output reg [`DSC_DITH_STEPS-1:0] dither_src_o,
  output reg dither_sign_o
);
  localparam integer LW = `DSC_LFSR_W;
  localparam [LW-1:0] SEED_P = SEED[LW-1:0];
  reg [LW-1:0] lfsr_q;
  reg [`DSC_RATE_W-1:0] shuf_cnt_q;
  reg [`DSC_RATE_W-1:0] dith_cnt_q;
  reg [`DSC_SEG_IDX_W-1:0] rot_up_q;
  reg [`DSC_SEG_IDX_W-1:0] rot_mid_q;
  reg [`DSC_DITH_IDX_W-1:0] dith_idx_q;
  reg dith_neg_q;
  reg [`DSC_WIDE_W-1:0] prev_q;
  reg [`DSC_OFS_W-1:0] ofs_sat;
  reg [`DSC_WIDE_W-1:0] dith_val;
  reg [`DSC_WIDE_W-1:0] wide_sum;
  reg [`DSC_WIDE_W-1:0] clip;
  reg [`DSC_SAMPLE_W-1:0] ob;
  reg [`DSC_UPPER_SEGS-1:0] therm_up;
  reg [`DSC_MIDDLE_SEGS-1:0] therm_mid;
  wire [`DSC_OFS_W-1:0] lim;
  wire [`DSC_OFS_W-1:0] nlim;
  wire shuf_tick;
  wire dith_tick;
  wire shuf_step;
  integer k;

  // Limit follows the live dither enable [R19] [R20] [R21]
  assign lim = dither_en_i ? `DSC_OFS_LIM_DITH : `DSC_OFS_LIM_NODITH;
  assign nlim = ~lim + {{(`DSC_OFS_W-1){1'b0}}, 1'b1};
  assign shuf_tick = (shuf_cnt_q == shuffle_rate_i);
  assign dith_tick = (dith_cnt_q == dither_rate_i);
  // Reduced activity: only reassign when the code moved [R13]
  assign shuf_step = shuf_tick & (~shuffle_activity_i | (prev_q != clip));

  // Saturate offset, add dither and offset in the widened path
  always @* begin
    ofs_sat = offset_i;
    if ($signed(offset_i) > $signed(lim)) begin
      ofs_sat = lim; // [R19] [R20]
    end else if ($signed(offset_i) < $signed(nlim)) begin
      ofs_sat = nlim; // [R19] [R20]
    end
    // Eight dither magnitudes, sign chosen by the generator [R14]
    // Step count is one bit wider so index 7 gives eight steps, not zero
    dith_val = {{(`DSC_WIDE_W-`DSC_DITH_IDX_W-`DSC_DITH_STEP_SHIFT-1){1'b0}},
                {1'b0, dith_idx_q} + 4'h1, {`DSC_DITH_STEP_SHIFT{1'b0}}};
    if (dith_neg_q) begin
      dith_val = ~dith_val + 18'h00001;
    end
    if (!dither_en_i) begin
      dith_val = {`DSC_WIDE_W{1'b0}};
    end
    // Offset joins before decode; widened so data range is kept [R17] [R21]
    wide_sum = {{2{sample_i[`DSC_SAMPLE_W-1]}}, sample_i}
             + {{(`DSC_WIDE_W-`DSC_OFS_W){ofs_sat[`DSC_OFS_W-1]}}, ofs_sat}
             + dith_val;
    clip = wide_sum;
    if ($signed(wide_sum) > $signed(`DSC_CODE_MAX)) begin
      clip = `DSC_CODE_MAX;
    end else if ($signed(wide_sum) < $signed(`DSC_CODE_MIN)) begin
      clip = `DSC_CODE_MIN;
    end
    // Code 0 sits mid-scale: offset binary for the switch array [R08]
    ob = {~clip[`DSC_SAMPLE_W-1], clip[`DSC_SAMPLE_W-2:0]};
    for (k = 0; k < `DSC_UPPER_SEGS; k = k + 1) begin
      therm_up[k] = (ob[15:12] > k);
      therm_mid[k] = (ob[11:8] > k);
    end
  end

  // Generator, rate dividers and segment rotation [R12] [R13] [R15]
  always @(posedge clk_i) begin
    if (reset_i) begin
      lfsr_q <= SEED_P;
      shuf_cnt_q <= {`DSC_RATE_W{1'b0}};
      dith_cnt_q <= {`DSC_RATE_W{1'b0}};
      rot_up_q <= {`DSC_SEG_IDX_W{1'b0}};
      rot_mid_q <= {`DSC_SEG_IDX_W{1'b0}};
      dith_idx_q <= {`DSC_DITH_IDX_W{1'b0}};
      dith_neg_q <= 1'b0;
      prev_q <= {`DSC_WIDE_W{1'b0}};
    end else if (sample_valid_i) begin
      lfsr_q <= {lfsr_q[LW-2:0], ^(lfsr_q & `DSC_LFSR_TAPS)};
      prev_q <= clip;
      shuf_cnt_q <= shuf_tick ? {`DSC_RATE_W{1'b0}} : shuf_cnt_q + 4'h1;
      dith_cnt_q <= dith_tick ? {`DSC_RATE_W{1'b0}} : dith_cnt_q + 4'h1;
      if (shuffle_en_i && shuf_step) begin
        rot_up_q <= (lfsr_q[3:0] == 4'hf) ? 4'h0 : lfsr_q[3:0]; // [R12]
        rot_mid_q <= (lfsr_q[7:4] == 4'hf) ? 4'h0 : lfsr_q[7:4]; // [R12]
      end else if (!shuffle_en_i) begin
        rot_up_q <= 4'h0;
        rot_mid_q <= 4'h0;
      end
      if (dith_tick) begin
        dith_idx_q <= lfsr_q[10:8]; // [R15]
        dith_neg_q <= lfsr_q[11];
      end
    end
  end

  // Registered switch drive; rotation picks which segments carry the value
  always @(posedge clk_i) begin
    if (reset_i) begin
      upper_seg_o <= {`DSC_UPPER_SEGS{1'b0}};
      middle_seg_o <= {`DSC_MIDDLE_SEGS{1'b0}};
      lower_bits_o <= {`DSC_LOWER_BITS{1'b0}};
      dither_src_o <= {`DSC_DITH_STEPS{1'b0}};
      dither_sign_o <= 1'b0;
    end else if (sample_valid_i) begin
      upper_seg_o <= (therm_up << rot_up_q) | (therm_up >> (5'd15 - rot_up_q)); // [R11]
      middle_seg_o <= (therm_mid << rot_mid_q) | (therm_mid >> (5'd15 - rot_mid_q));
      lower_bits_o <= ob[7:0]; // [R11]
      // Extra sources cancel the injected dither with equal weight [R14]
      dither_src_o <= dither_en_i ? ({`DSC_DITH_STEPS{1'b1}} >> (3'h7 - dith_idx_q))
                                  : {`DSC_DITH_STEPS{1'b0}};
      dither_sign_o <= dither_en_i & ~dith_neg_q;
    end
  end
endmodule

//--- rtl/dsc_top.v
// Sample conditioning top: waveform modes, interpolation and two channels
// What this block does
// R01 - Mixing mode outputs sample first half-period, its negation the second half.
// R02 - Dual-edge mode gives a distinct sample per clock edge via interpolate by two.
// R03 - Three dual-edge variants; unique-data variant takes distinct samples at doubled rate.
// R04 - Low-pass variant doubles rate with a low-pass 2x interpolation filter.
// R05 - High-pass variant uses a high-pass interpolation filter, same bandwidth.
// R06 - Clock source gives core rate, or half of it in dual-edge mode. Here no clock is produced; clk_i is used undivided in every mode.
// R07 - Two independent 16-bit cores, each with own current, shuffle, dither, offset.
// R08 - Code 0 splits current evenly; +32767 positive leg, -32768 negative leg.
// R09 - Per channel 4-bit coarse current level and 6-bit fine current trim.
// R10 - Current double select scales switched and static currents by two.
// R11 - Core uses upper and middle thermometer segments, binary low bits, dither sources.
// R12 - Shuffling randomizes which upper and middle segments build each value.
// R13 - Per-channel rate and shared activity select control segment reassignment.
// R14 - Dither adds one of eight codes, cancelled by extra sources, range kept.
// R15 - Per-channel dither rate select sets how often dither value changes.
// R16 - Software picks reduced activity below 750MHz, normal above.
// R17 - Per-channel offset applied without reducing the 16-bit data range.
// R18 - Offset index 0 goes to channel A, index 1 to channel B.
// R19 - With dither on, offset saturates to plus or minus 128.
// R20 - With dither off, offset saturates to plus or minus 3968.
// R21 - Saturated offset added before decode; limit follows live dither enable.
`timescale 1ns/10ps
`include "dsc_consts.vh"
module dsc_top (
  input wire clk_i,
  input wire reset_i,
  input wire [`DSC_MODE_W-1:0] mode_i,
  input wire sample_valid_i,
  input wire [`DSC_SAMPLE_W-1:0] sample_a_i,
  input wire [`DSC_SAMPLE_W-1:0] sample_b_i,
  input wire [`DSC_SAMPLE_W-1:0] sample_a_odd_i,
  input wire [`DSC_SAMPLE_W-1:0] sample_b_odd_i,
  input wire [`DSC_OFS_W-1:0] offset_value0_i,
  input wire [`DSC_OFS_W-1:0] offset_value1_i,
  input wire [1:0] shuffle_en_i,
  input wire [1:0] dither_en_i,
  input wire shuffle_activity_i,
  input wire [`DSC_RATE_W-1:0] shuffle_rate_a_i,
  input wire [`DSC_RATE_W-1:0] shuffle_rate_b_i,
  input wire [`DSC_RATE_W-1:0] dither_rate_a_i,
  input wire [`DSC_RATE_W-1:0] dither_rate_b_i,
  input wire [`DSC_COARSE_W-1:0] coarse_current_level_a_i,
  input wire [`DSC_COARSE_W-1:0] coarse_current_level_b_i,
  input wire [`DSC_FINE_W-1:0] fine_current_trim_a_i,
  input wire [`DSC_FINE_W-1:0] fine_current_trim_b_i,
  input wire current_double_select_i,
  output reg [`DSC_COARSE_W-1:0] coarse_current_level_a_o,
  output reg [`DSC_COARSE_W-1:0] coarse_current_level_b_o,
  output reg [`DSC_FINE_W-1:0] fine_current_trim_a_o,
  output reg [`DSC_FINE_W-1:0] fine_current_trim_b_o,
  output reg current_scale_switched_o,
  output reg current_scale_static_o,
  output reg [`DSC_SAMPLE_W-1:0] rise_a_o,
  output reg [`DSC_SAMPLE_W-1:0] fall_a_o,
  output reg [`DSC_SAMPLE_W-1:0] rise_b_o,
  output reg [`DSC_SAMPLE_W-1:0] fall_b_o,
  output reg fall_zero_o,
  output wire [29:0] upper_seg_o,
  output wire [29:0] middle_seg_o,
  output wire [15:0] lower_bits_o,
  output wire [15:0] dither_src_o,
  output wire [1:0] dither_sign_o
);
  // Half-band taps in sixteenths for the 2x interpolator
  localparam signed [7:0] TAP_NEAR = 8'sh09;
  localparam signed [7:0] TAP_FAR = 8'shff;

  reg [`DSC_SAMPLE_W-1:0] hist_q [0:1][0:3];
  reg [`DSC_SAMPLE_W-1:0] even_s [0:1];
  reg [`DSC_SAMPLE_W-1:0] odd_s [0:1];
  wire [`DSC_SAMPLE_W-1:0] in_s [0:1];
  wire [`DSC_SAMPLE_W-1:0] in_odd_s [0:1];
  wire [`DSC_OFS_W-1:0] ofs_s [0:1];
  wire [`DSC_RATE_W-1:0] shr_s [0:1];
  wire [`DSC_RATE_W-1:0] dir_s [0:1];
  wire [`DSC_SAMPLE_W-1:0] cond_s [0:1];
  reg signed [23:0] acc;
  reg [`DSC_SAMPLE_W-1:0] interp;
  integer c;
  integer h;
  integer j;

  assign in_s[0] = sample_a_i;
  assign in_s[1] = sample_b_i;
  assign in_odd_s[0] = sample_a_odd_i;
  assign in_odd_s[1] = sample_b_odd_i;
  // Index 0 drives channel A, index 1 channel B [R18]
  assign ofs_s[0] = offset_value0_i;
  assign ofs_s[1] = offset_value1_i;
  assign shr_s[0] = shuffle_rate_a_i;
  assign shr_s[1] = shuffle_rate_b_i;
  assign dir_s[0] = dither_rate_a_i;
  assign dir_s[1] = dither_rate_b_i;

  // Input history for the interpolator, per channel
  always @(posedge clk_i) begin
    if (reset_i) begin
      for (h = 0; h < 2; h = h + 1) begin
        for (j = 0; j < 4; j = j + 1) begin
          hist_q[h][j] <= {`DSC_SAMPLE_W{1'b0}};
        end
      end
    end else if (sample_valid_i) begin
      for (h = 0; h < 2; h = h + 1) begin
        hist_q[h][0] <= in_s[h];
        hist_q[h][1] <= hist_q[h][0];
        hist_q[h][2] <= hist_q[h][1];
        hist_q[h][3] <= hist_q[h][2];
      end
    end
  end

  // Even/odd pair per mode; even is the older neighbour of the midpoint, so time order holds
  always @* begin
    acc = 24'sh0;
    interp = {`DSC_SAMPLE_W{1'b0}};
    for (c = 0; c < 2; c = c + 1) begin
      // Four-tap half-band midpoint between hist 1 and hist 2 [R02] [R04]
      acc = TAP_NEAR * ($signed(hist_q[c][1]) + $signed(hist_q[c][2]))
          + TAP_FAR * ($signed(hist_q[c][0]) + $signed(hist_q[c][3]));
      acc = acc >>> 4;
      if (acc > 24'sh007fff) begin
        interp = 16'h7fff;
      end else if (acc < -24'sh008000) begin
        interp = 16'h8000;
      end else begin
        interp = acc[15:0];
      end
      even_s[c] = in_s[c];
      odd_s[c] = in_s[c];
      case (mode_i)
        `DSC_MODE_DE_UNIQUE: begin
          odd_s[c] = in_odd_s[c]; // [R03]
        end
        `DSC_MODE_DE_LOWPASS: begin
          even_s[c] = hist_q[c][2]; // [R04]
          odd_s[c] = interp;
        end
        `DSC_MODE_DE_HIGHPASS: begin
          // Alternate-sign images: negate odd outputs to flip the spectrum [R05]
          even_s[c] = hist_q[c][2];
          odd_s[c] = (interp == 16'h8000) ? 16'h7fff : (~interp + 16'h0001);
        end
        default: begin
          odd_s[c] = in_s[c];
        end
      endcase
    end
  end

  // Two independent conditioned cores [R07]
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      dsc_channel #(
        .SEED(`DSC_LFSR_SEED ^ (g * 16'h1357))
      ) u_ch (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .sample_valid_i(sample_valid_i),
        .sample_i(even_s[g]),
        .offset_i(ofs_s[g]),
        .dither_en_i(dither_en_i[g]),
        .shuffle_en_i(shuffle_en_i[g]),
        .shuffle_activity_i(shuffle_activity_i),
        .shuffle_rate_i(shr_s[g]),
        .dither_rate_i(dir_s[g]),
        .upper_seg_o(upper_seg_o[g*15 +: 15]),
        .middle_seg_o(middle_seg_o[g*15 +: 15]),
        .lower_bits_o(lower_bits_o[g*8 +: 8]),
        .dither_src_o(dither_src_o[g*8 +: 8]),
        .dither_sign_o(dither_sign_o[g])
      );
      assign cond_s[g] = even_s[g];
    end
  endgenerate

  // Per-edge waveform: mix mode negates the second half-period [R01]
  always @(posedge clk_i) begin
    if (reset_i) begin
      rise_a_o <= {`DSC_SAMPLE_W{1'b0}};
      fall_a_o <= {`DSC_SAMPLE_W{1'b0}};
      rise_b_o <= {`DSC_SAMPLE_W{1'b0}};
      fall_b_o <= {`DSC_SAMPLE_W{1'b0}};
      fall_zero_o <= 1'b0;
    end else if (sample_valid_i) begin
      rise_a_o <= cond_s[0];
      rise_b_o <= cond_s[1];
      fall_zero_o <= (mode_i == `DSC_MODE_RTZ);
      if (mode_i == `DSC_MODE_MIX) begin
        fall_a_o <= (cond_s[0] == 16'h8000) ? 16'h7fff : (~cond_s[0] + 16'h0001); // [R01]
        fall_b_o <= (cond_s[1] == 16'h8000) ? 16'h7fff : (~cond_s[1] + 16'h0001);
      end else if (mode_i == `DSC_MODE_RTZ) begin
        fall_a_o <= {`DSC_SAMPLE_W{1'b0}};
        fall_b_o <= {`DSC_SAMPLE_W{1'b0}};
      end else if (mode_i >= `DSC_MODE_DE_UNIQUE) begin
        fall_a_o <= odd_s[0]; // [R02]
        fall_b_o <= odd_s[1];
      end else begin
        fall_a_o <= cond_s[0];
        fall_b_o <= cond_s[1];
      end
    end
  end

  // Current settings registered toward the bias array [R09] [R10]
  always @(posedge clk_i) begin
    if (reset_i) begin
      coarse_current_level_a_o <= {`DSC_COARSE_W{1'b0}};
      coarse_current_level_b_o <= {`DSC_COARSE_W{1'b0}};
      fine_current_trim_a_o <= {`DSC_FINE_W{1'b0}};
      fine_current_trim_b_o <= {`DSC_FINE_W{1'b0}};
      current_scale_switched_o <= 1'b0;
      current_scale_static_o <= 1'b0;
    end else begin
      coarse_current_level_a_o <= coarse_current_level_a_i; // [R09]
      coarse_current_level_b_o <= coarse_current_level_b_i;
      fine_current_trim_a_o <= fine_current_trim_a_i;
      fine_current_trim_b_o <= fine_current_trim_b_i;
      current_scale_switched_o <= current_double_select_i; // [R10]
      current_scale_static_o <= current_double_select_i; // [R10]
    end
  end
endmodule

//--- sim/dsc_switch_array.sv
// Switch array model: rebuilds the steered code of each channel
`timescale 1ns/10ps
module dsc_switch_array (
  input wire logic [29:0] upper_i,
  input wire logic [29:0] middle_i,
  input wire logic [15:0] lower_i,
  output logic [31:0] code_a_o,
  output logic [31:0] code_b_o
);
  // Upper segments weigh 4096, middle 256, lower bits binary; only counts matter
  always_comb begin
    code_a_o = $countones(upper_i[14:0])*4096 + $countones(middle_i[14:0])*256 + lower_i[7:0];
    code_b_o = $countones(upper_i[29:15])*4096 + $countones(middle_i[29:15])*256 + lower_i[15:8];
  end
endmodule

//--- sim/dsc_top_properties.sv
// Port checker for the conditioning top
`timescale 1ns/10ps
`include "dsc_consts.vh"
module dsc_top_properties (
  input wire clk_i,
  input wire reset_i,
  input wire [2:0] mode_i,
  input wire sample_valid_i,
  input wire [15:0] sample_a_i,
  input wire [15:0] sample_a_odd_i,
  input wire [12:0] offset_value0_i,
  input wire [1:0] dither_en_i,
  input wire [3:0] coarse_current_level_a_i,
  input wire [5:0] fine_current_trim_a_i,
  input wire current_double_select_i,
  input wire [3:0] coarse_current_level_a_o,
  input wire [5:0] fine_current_trim_a_o,
  input wire current_scale_switched_o,
  input wire current_scale_static_o,
  input wire [15:0] rise_a_o,
  input wire [15:0] fall_a_o,
  input wire [29:0] upper_seg_o,
  input wire [29:0] middle_seg_o,
  input wire [15:0] lower_bits_o,
  input wire [15:0] dither_src_o,
  input wire [1:0] dither_sign_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  int code_a;
  int dith_a;
  // Channel A code from segment counts, so shuffling cannot hide a wrong value
  always_comb begin
    code_a = $countones(upper_seg_o[14:0])*4096 + $countones(middle_seg_o[14:0])*256;
    code_a = code_a + lower_bits_o[7:0];
    dith_a = $countones(dither_src_o[7:0]) * 16;
  end
  // Offset clipped to the dither-dependent limit, sum kept in the 16-bit range
  function automatic int ecode(logic [15:0] s, logic [12:0] o, logic d);
    int lim;
    int v;
    lim = d ? 128 : 3968;
    v = $signed(o);
    v = v > lim ? lim : (v < -lim ? -lim : v);
    v = v + $signed(s);
    return (v > 32767 ? 32767 : (v < -32768 ? -32768 : v)) + 32768;
  endfunction
  sequence take_hold;
    sample_valid_i && mode_i == `DSC_MODE_HOLD;
  endsequence
  sequence calm_a;
    $signed(sample_a_i) > -30000 && $signed(sample_a_i) < 30000;
  endsequence
  // Constant small input held long enough to flush the interpolator
  sequence flat_interp;
    (sample_valid_i && mode_i >= `DSC_MODE_DE_LOWPASS && $stable(mode_i) && $stable(sample_a_i)
      && (sample_a_i[15:12] == 4'h0 || sample_a_i[15:12] == 4'hf))[*8];
  endsequence
  a_fields_follow:
    assert property (1'b1 |=> coarse_current_level_a_o == $past(coarse_current_level_a_i)
      && fine_current_trim_a_o == $past(fine_current_trim_a_i))
    else $error("current fields not passed on");
  a_double_both:
    assert property (1'b1 |=> current_scale_switched_o == $past(current_double_select_i)
      && current_scale_static_o == current_scale_switched_o)
    else $error("current doubling wrong");
  a_mix_negate:
    assert property (sample_valid_i && mode_i == `DSC_MODE_MIX |=> rise_a_o == $past(sample_a_i)
      && fall_a_o == ($past(sample_a_i) == 16'h8000 ? 16'h7fff : -$past(sample_a_i)))
    else $error("mixing halves wrong");
  a_dual_pair:
    assert property (sample_valid_i && mode_i == `DSC_MODE_DE_UNIQUE |=>
      rise_a_o == $past(sample_a_i) && fall_a_o == $past(sample_a_odd_i))
    else $error("dual-edge pair wrong");
  a_plain_offset:
    assert property (take_hold ##0 !dither_en_i[0] |=>
      code_a == ecode($past(sample_a_i), $past(offset_value0_i), 1'b0))
    else $error("undithered offset code wrong");
  a_dither_offset:
    assert property (take_hold ##0 calm_a ##0 dither_en_i[0] |=> (dither_sign_o[0] ?
      code_a - ecode($past(sample_a_i), $past(offset_value0_i), 1'b1) :
      ecode($past(sample_a_i), $past(offset_value0_i), 1'b1) - code_a) == dith_a)
    else $error("dithered offset code wrong");
  a_dither_off_b:
    assert property (sample_valid_i && !dither_en_i[1] |=> dither_src_o[15:8] == 8'h00
      && !dither_sign_o[1])
    else $error("channel B dither sources active while off");
  a_dither_steps:
    assert property (take_hold ##0 dither_en_i[0] |=> dith_a >= 16 && dith_a <= 128)
    else $error("dither step outside eight values");
  a_interp_dc:
    assert property (flat_interp |=> rise_a_o == $past(sample_a_i) && fall_a_o ==
      ($past(mode_i) == `DSC_MODE_DE_HIGHPASS ? -rise_a_o : rise_a_o))
    else $error("interpolated level wrong");
endmodule

//--- sim/testbench.sv
// Self-checking bench for the conditioning top
`timescale 1ns/10ps
`include "dsc_consts.vh"
module testbench;
  logic clk_i = 0, reset_i = 1, sample_valid_i = 0, shuffle_activity_i = 0;
  logic current_double_select_i = 0;
  logic [2:0] mode_i = 0;
  logic [15:0] sample_a_i = 0, sample_b_i = 0, sample_a_odd_i = 0, sample_b_odd_i = 0;
  logic [12:0] offset_value0_i = 0, offset_value1_i = 0;
  logic [1:0] shuffle_en_i = 0, dither_en_i = 0;
  logic [3:0] shuffle_rate_a_i = 0, shuffle_rate_b_i = 0, dither_rate_a_i = 0, dither_rate_b_i = 0;
  logic [3:0] coarse_current_level_a_i = 0, coarse_current_level_b_i = 0;
  logic [5:0] fine_current_trim_a_i = 0, fine_current_trim_b_i = 0;
  wire [3:0] coarse_current_level_a_o, coarse_current_level_b_o;
  wire [5:0] fine_current_trim_a_o, fine_current_trim_b_o;
  wire current_scale_switched_o, current_scale_static_o, fall_zero_o;
  wire [15:0] rise_a_o, fall_a_o, rise_b_o, fall_b_o, lower_bits_o, dither_src_o;
  wire [29:0] upper_seg_o, middle_seg_o;
  wire [1:0] dither_sign_o;
  logic [31:0] code_a, code_b;
  int checks = 0, n_fail = 0, o0 = 0, o1 = 0, de = 0, s;
  int q[$];
  int ofs[8] = '{0, 127, 128, -129, 3967, 3968, 4095, -4096};
  int ext[4] = '{32767, -32768, 0, 100};
  int md[4] = '{0, 1, 2, 3};
  dsc_top dut (.clk_i, .reset_i, .mode_i, .sample_valid_i, .sample_a_i, .sample_b_i,
    .sample_a_odd_i, .sample_b_odd_i, .offset_value0_i, .offset_value1_i, .shuffle_en_i,
    .dither_en_i, .shuffle_activity_i, .shuffle_rate_a_i, .shuffle_rate_b_i, .dither_rate_a_i,
    .dither_rate_b_i, .coarse_current_level_a_i, .coarse_current_level_b_i,
    .fine_current_trim_a_i, .fine_current_trim_b_i, .current_double_select_i,
    .coarse_current_level_a_o, .coarse_current_level_b_o, .fine_current_trim_a_o,
    .fine_current_trim_b_o, .current_scale_switched_o, .current_scale_static_o, .rise_a_o,
    .fall_a_o, .rise_b_o, .fall_b_o, .fall_zero_o, .upper_seg_o, .middle_seg_o, .lower_bits_o,
    .dither_src_o, .dither_sign_o);
  dsc_switch_array far (.upper_i(upper_seg_o), .middle_i(middle_seg_o), .lower_i(lower_bits_o),
    .code_a_o(code_a), .code_b_o(code_b));
  // Device clock at the core sample rate
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  function automatic int rs(int r);
    return int'($urandom_range(2 * r)) - r;
  endfunction
  // Model code: offset clipped by dither state, then offset binary
  function automatic int ecode(int v, int o, int d);
    int lim;
    lim = d ? 128 : 3968;
    o = o > lim ? lim : (o < -lim ? -lim : o);
    v = v + o;
    return (v > 32767 ? 32767 : (v < -32768 ? -32768 : v)) + 32768;
  endfunction
  // Model falling half; -1 marks a value that is not compared
  function automatic int fe(int m, int a, int ao);
    a = a & 16'hffff;
    if (m == 2) return a == 16'h8000 ? 16'h7fff : (-a) & 16'hffff;
    if (m == 3) return ao & 16'hffff;
    return m < 2 ? (m ? 0 : a) : -1;
  endfunction
  task automatic chk(logic [31:0] got, int e);
    if (e != -1) begin
      checks++;
      if (got !== e) begin
        n_fail++;
        $display("[ERR] at %0t got %h expected %h", $time, got, e);
      end
    end
  endtask
  // Check the last answer, then drive a sample; all inputs move here so expectations hold
  task automatic step(int m, int a, int b, int ao, int bo);
    @(posedge clk_i);
    #1;
    if (q.size() > 0) begin
      chk(rise_a_o, q.pop_front());
      chk(fall_a_o, q.pop_front());
      chk(rise_b_o, q.pop_front());
      chk(fall_b_o, q.pop_front());
      chk(code_a, q.pop_front());
      chk(code_b, q.pop_front());
      chk({coarse_current_level_a_o, coarse_current_level_b_o, fine_current_trim_a_o,
        fine_current_trim_b_o, current_scale_switched_o, current_scale_static_o, fall_zero_o},
        q.pop_front());
    end
    // Any shuffle activity may be tried per use case
    {shuffle_en_i, shuffle_activity_i, current_double_select_i} = 4'($urandom);
    {shuffle_rate_a_i, shuffle_rate_b_i, dither_rate_a_i, dither_rate_b_i} = 16'($urandom);
    {coarse_current_level_a_i, coarse_current_level_b_i} = 8'($urandom);
    {fine_current_trim_a_i, fine_current_trim_b_i} = 12'($urandom);
    {mode_i, sample_valid_i, dither_en_i} = {3'(m), 1'b1, 2'(de)};
    {offset_value0_i, offset_value1_i} = {13'(o0), 13'(o1)};
    {sample_a_i, sample_b_i, sample_a_odd_i, sample_b_odd_i} = {16'(a), 16'(b), 16'(ao), 16'(bo)};
    q.push_back(m >= 4 ? -1 : a & 16'hffff);
    q.push_back(fe(m, a, ao));
    q.push_back(m >= 4 ? -1 : b & 16'hffff);
    q.push_back(fe(m, b, bo));
    q.push_back(m < 4 && !de[0] ? ecode(a, o0, 0) : -1);
    q.push_back(m < 4 && !de[1] ? ecode(b, o1, 0) : -1);
    q.push_back({coarse_current_level_a_i, coarse_current_level_b_i, fine_current_trim_a_i,
      fine_current_trim_b_i, current_double_select_i, current_double_select_i, m == 1});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Cut a hang short; the tests need about two hundred cycles
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial begin
    s = $urandom(10);
    repeat (12) @(posedge clk_i);
    #1;
    reset_i = 0;
    chk(rise_a_o, 0);
    chk(upper_seg_o, 0);
    // Hold, return-to-zero, mixing and unique dual-edge data with full-scale extremes mixed in
    foreach (md[k]) begin
      repeat (30) begin
        {o0, o1, s} = {rs(4095), rs(4095), int'($urandom_range(9))};
        step(md[k], s < 2 ? ext[s] : rs(32767), rs(32767), rs(32767), rs(32767));
      end
    end
    $display("test modes done");
    // Offset limits at their edges, with and without dither, index mapping per channel
    foreach (ofs[k]) begin
      for (int d = 0; d < 2; d++) begin
        {o0, o1, de} = {ofs[k], ofs[7 - k], 3 * d};
        foreach (ext[j]) step(0, ext[j], rs(16000), 0, 0);
      end
    end
    de = 0;
    $display("test offsets done");
    // Interpolating variants settle to the level, high-pass one with odd halves inverted
    for (int k = 0; k < 2; k++) begin
      s = rs(4000);
      repeat (13) step(4 + k, s, s, 0, 0);
      chk(rise_a_o, s & 16'hffff);
      chk(fall_a_o, (k ? -s : s) & 16'hffff);
    end
    step(0, 5, 6, 0, 0);
    step(0, 7, 8, 0, 0);
    $display("test interpolation done");
    end_of_test();
  end
endmodule
bind dsc_top dsc_top_properties u_chk (.clk_i, .reset_i, .mode_i, .sample_valid_i, .sample_a_i,
  .sample_a_odd_i, .offset_value0_i, .dither_en_i, .coarse_current_level_a_i,
  .fine_current_trim_a_i, .current_double_select_i, .coarse_current_level_a_o,
  .fine_current_trim_a_o, .current_scale_switched_o, .current_scale_static_o, .rise_a_o,
  .fall_a_o, .upper_seg_o, .middle_seg_o, .lower_bits_o, .dither_src_o, .dither_sign_o);
